// ==== logic/host_register_map_consts.svh ====
// register offsets, field positions, reset values and bus constants of the host register map
`ifndef HOST_REGISTER_MAP_CONSTS_SVH
`define HOST_REGISTER_MAP_CONSTS_SVH

// ----------------------------------------
// serial slave
// ----------------------------------------
`define I2C_DEV_ADDR 7'h49

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_BOOT_VERSION_MINOR 8'h00
`define REG_BOOT_VERSION_MAJOR 8'h01
`define REG_APP_VERSION_MINOR 8'h02
`define REG_APP_VERSION_MAJOR 8'h03
`define REG_OP_MODE_LOW 8'h04
`define REG_OP_MODE_HIGH 8'h05
`define REG_SYS_RESET_KEY_LOW 8'h06
`define REG_SYS_RESET_KEY_HIGH 8'h07
`define REG_MAIN_EVENT_SUMMARY 8'h08
`define REG_EVENT_GROUP_ZERO 8'h09
`define REG_EVENT_GROUP_ONE 8'h0a
`define REG_EVENT_GROUP_TWO 8'h0b
`define REG_EVENT_GROUP_THREE 8'h0c
`define REG_RESERVED_FIRST 8'h0d

// ----------------------------------------
// fields and values
// ----------------------------------------
`define LOADER_ACTIVE_BIT 0
`define OP_MODE_HIGH_RESET 8'h00
`define SYS_RESET_KEY_RESET 8'h00
`define SYS_RESET_KEY_HIGH_VALUE 8'haa
`define SYS_RESET_KEY_LOW_VALUE 8'h55
`define RESERVED_READ_VALUE 8'h00

`endif

// ==== logic/host_register_map_pkg.sv ====
// types shared by the host register map and its serial slave engine
package host_register_map_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wbyte,
        st_wack,
        st_rbyte,
        st_rack
    } slave_state_type;

endpackage : host_register_map_pkg

// ==== logic/reg_link_if.sv ====
// byte link between the serial slave engine and the register bank
`timescale 1ns/10ps
interface reg_link_if;
    logic byte_valid;
    logic byte_first;
    logic [7:0] byte_data;
    logic rd_req;
    logic [7:0] rd_data;

    modport engine (output byte_valid, output byte_first, output byte_data, output rd_req, input rd_data);
    modport bank (input byte_valid, input byte_first, input byte_data, input rd_req, output rd_data);
endinterface : reg_link_if

// ==== logic/i2c_slave_engine.sv ====
// serial slave engine: start/stop detect, address match, byte shift and acknowledge
`timescale 1ns/10ps
`include "host_register_map_consts.svh"
module i2c_slave_engine
    import host_register_map_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe,
    // register side
    reg_link_if.engine link
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] scl_q, scl_d;
    logic [2:0] sda_q, sda_d;

    always_comb
    begin
        scl_d = {scl_q[1:0], scl_in};
        sda_d = {sda_q[1:0], sda_in};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 3'b111;
            sda_q <= 3'b111;
        end
        else
        begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // stage 0 feeds only stage 1; edges use stages 1 and 2
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = scl_q[1];
    assign sda_s = sda_q[1];
    assign scl_rise = scl_s && !scl_q[2];
    assign scl_fall = !scl_s && scl_q[2];
    assign start_det = scl_s && scl_q[2] && sda_q[2] && !sda_s;
    assign stop_det = scl_s && scl_q[2] && !sda_q[2] && sda_s;

    // ----------------------------------------
    // protocol state
    // ----------------------------------------
    slave_state_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic oe_q, oe_d;
    logic rw_q, rw_d;
    logic first_q, first_d;
    logic mack_q, mack_d;
    logic valid_d, rd_req_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        oe_d = oe_q;
        rw_d = rw_q;
        first_d = first_q;
        mack_d = mack_q;
        valid_d = 1'b0;
        rd_req_d = 1'b0;
        if (start_det)
        begin
            state_d = st_addr;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end
        else if (stop_det)
        begin
            state_d = st_idle;
            oe_d = 1'b0;
        end
        else
        begin
            case (state_q)
                st_addr, st_wbyte:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == 4'h8)
                    begin
                        cnt_d = 4'h0;
                        if (state_q == st_wbyte)
                        begin
                            // every data byte is acknowledged, even to read-only registers
                            valid_d = 1'b1;
                            oe_d = 1'b1;
                            state_d = st_wack;
                        end
                        else if (sh_q[7:1] == `I2C_DEV_ADDR)
                        begin
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                            state_d = st_addr_ack;
                        end
                        else
                        begin
                            state_d = st_idle;
                        end
                    end
                end
                st_wack:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        first_d = 1'b0;
                        state_d = st_wbyte;
                    end
                end
                st_addr_ack:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        if (rw_q)
                        begin
                            rd_req_d = 1'b1;
                            sh_d = link.rd_data;
                            oe_d = !link.rd_data[7];
                            state_d = st_rbyte;
                        end
                        else
                        begin
                            oe_d = 1'b0;
                            first_d = 1'b1;
                            state_d = st_wbyte;
                        end
                    end
                end
                st_rbyte:
                begin
                    if (scl_rise)
                    begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            oe_d = 1'b0;
                            state_d = st_rack;
                        end
                        else
                        begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = !sh_q[6];
                        end
                    end
                end
                st_rack:
                begin
                    if (scl_rise)
                    begin
                        mack_d = !sda_s;
                    end
                    else if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        if (mack_q)
                        begin
                            rd_req_d = 1'b1;
                            sh_d = link.rd_data;
                            oe_d = !link.rd_data[7];
                            state_d = st_rbyte;
                        end
                        else
                        begin
                            state_d = st_idle;
                        end
                    end
                end
                default:
                begin
                    state_d = st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= st_idle;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            oe_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            mack_q <= 1'b0;
            link.byte_valid <= 1'b0;
            link.byte_first <= 1'b0;
            link.byte_data <= 8'h00;
            link.rd_req <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            oe_q <= oe_d;
            rw_q <= rw_d;
            first_q <= first_d;
            mack_q <= mack_d;
            link.byte_valid <= valid_d;
            link.byte_first <= first_q;
            link.byte_data <= sh_q;
            link.rd_req <= rd_req_d;
        end
    end

    assign sda_oe = oe_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_addr_mismatch: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == st_addr && !start_det && !stop_det && scl_fall && cnt_q == 4'h8
        && sh_q[7:1] != `I2C_DEV_ADDR |=> !oe_q && state_q == st_idle)
        else $error("foreign address acknowledged");

endmodule : i2c_slave_engine

// ==== logic/host_register_map.sv ====
// host register bank reached over the serial slave port
`timescale 1ns/10ps
`include "host_register_map_consts.svh"

// Summary of operation
// - offset 0x00 reads loader minor version
// - offset 0x01 reads loader major version
// - offset 0x02 reads application minor version
// - offset 0x03 reads application major version
// - offset 0x04 bit 0 shows loader mode
// - offsets 0x0D upward are reserved
// - slave answers only at address 0x49
// - burst bytes go to ascending offsets
// - reset only when both keys correct
module host_register_map
    import host_register_map_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // firmware side values
    input wire logic [7:0] boot_version_minor,
    input wire logic [7:0] boot_version_major,
    input wire logic [7:0] app_version_minor,
    input wire logic [7:0] app_version_major,
    input wire logic loader_active_flag,
    input wire logic [7:0] main_event_summary,
    input wire logic [7:0] event_group_zero,
    input wire logic [7:0] event_group_one,
    input wire logic [7:0] event_group_two,
    input wire logic [7:0] event_group_three,
    // control outputs
    output logic [7:0] op_mode_high,
    output logic sys_reset_req
);

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    reg_link_if link ();
    logic engine_oe;

    i2c_slave_engine u_engine (
        .mclk (mclk),
        .rst_n (rst_n),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .sda_oe (engine_oe),
        .link (link)
    );

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] op_mode_high_q, op_mode_high_d;
    logic [7:0] key_low_q, key_low_d;
    logic [7:0] key_high_q, key_high_d;
    logic sys_reset_req_q, sys_reset_req_d;
    logic [7:0] rd_mux;

    // version and status bytes are live from the firmware side, no reset constant
    always_comb
    begin
        rd_mux = `RESERVED_READ_VALUE;
        if (ptr_q == `REG_BOOT_VERSION_MINOR)
            rd_mux = boot_version_minor;
        else if (ptr_q == `REG_BOOT_VERSION_MAJOR)
            rd_mux = boot_version_major;
        else if (ptr_q == `REG_APP_VERSION_MINOR)
            rd_mux = app_version_minor;
        else if (ptr_q == `REG_APP_VERSION_MAJOR)
            rd_mux = app_version_major;
        else if (ptr_q == `REG_OP_MODE_LOW)
        begin
            rd_mux = 8'h00;
            rd_mux[`LOADER_ACTIVE_BIT] = loader_active_flag;
        end
        else if (ptr_q == `REG_OP_MODE_HIGH)
            rd_mux = op_mode_high_q;
        else if (ptr_q == `REG_SYS_RESET_KEY_LOW)
            rd_mux = key_low_q;
        else if (ptr_q == `REG_SYS_RESET_KEY_HIGH)
            rd_mux = key_high_q;
        else if (ptr_q == `REG_MAIN_EVENT_SUMMARY)
            rd_mux = main_event_summary;
        else if (ptr_q == `REG_EVENT_GROUP_ZERO)
            rd_mux = event_group_zero;
        else if (ptr_q == `REG_EVENT_GROUP_ONE)
            rd_mux = event_group_one;
        else if (ptr_q == `REG_EVENT_GROUP_TWO)
            rd_mux = event_group_two;
        else if (ptr_q == `REG_EVENT_GROUP_THREE)
            rd_mux = event_group_three;
    end

    assign link.rd_data = rd_mux;

    // ----------------------------------------
    // pointer and writable registers
    // ----------------------------------------
    always_comb
    begin
        ptr_d = ptr_q;
        op_mode_high_d = op_mode_high_q;
        key_low_d = key_low_q;
        key_high_d = key_high_q;
        sys_reset_req_d = 1'b0;
        if (link.byte_valid && link.byte_first)
        begin
            ptr_d = link.byte_data;
        end
        else if (link.byte_valid)
        begin
            ptr_d = ptr_q + 8'h01;
            // offsets below 0x05 and above 0x07 keep their value
            if (ptr_q == `REG_OP_MODE_HIGH)
                op_mode_high_d = link.byte_data;
            else if (ptr_q == `REG_SYS_RESET_KEY_LOW)
                key_low_d = link.byte_data;
            else if (ptr_q == `REG_SYS_RESET_KEY_HIGH)
                key_high_d = link.byte_data;
            // either order of the two key writes arms the reset; keys clear so it fires once
            if (key_low_d == `SYS_RESET_KEY_LOW_VALUE && key_high_d == `SYS_RESET_KEY_HIGH_VALUE)
            begin
                sys_reset_req_d = 1'b1;
                key_low_d = `SYS_RESET_KEY_RESET;
                key_high_d = `SYS_RESET_KEY_RESET;
            end
        end
        else if (link.rd_req)
        begin
            ptr_d = ptr_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_q <= 8'h00;
            op_mode_high_q <= `OP_MODE_HIGH_RESET;
            key_low_q <= `SYS_RESET_KEY_RESET;
            key_high_q <= `SYS_RESET_KEY_RESET;
            sys_reset_req_q <= 1'b0;
        end
        else
        begin
            ptr_q <= ptr_d;
            op_mode_high_q <= op_mode_high_d;
            key_low_q <= key_low_d;
            key_high_q <= key_high_d;
            sys_reset_req_q <= sys_reset_req_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // the slave never stretches the clock, so its clock driver stays off
    logic scl_oe_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            scl_oe_q <= 1'b0;
        else
            scl_oe_q <= 1'b0;
    end

    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_out = 1'b0;
    assign sda_oe = engine_oe;
    assign op_mode_high = op_mode_high_q;
    assign sys_reset_req = sys_reset_req_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_boot_minor_read: assert property (link.rd_req && ptr_q == 8'h00 |-> link.rd_data == boot_version_minor)
        else $error("loader minor version misread");
    a_boot_major_read: assert property (link.rd_req && ptr_q == 8'h01 |-> link.rd_data == boot_version_major)
        else $error("loader major version misread");
    a_app_minor_read: assert property (link.rd_req && ptr_q == 8'h02 |-> link.rd_data == app_version_minor)
        else $error("application minor version misread");
    a_app_major_read: assert property (link.rd_req && ptr_q == 8'h03 |-> link.rd_data == app_version_major)
        else $error("application major version misread");
    a_mode_flag_read: assert property (link.rd_req && ptr_q == 8'h04
        |-> link.rd_data == {7'h00, loader_active_flag})
        else $error("mode byte misread");
    a_reserved_zero: assert property (link.rd_req && ptr_q >= 8'h0d |-> link.rd_data == 8'h00)
        else $error("reserved offset not zero");
    a_ptr_advance: assert property ((link.byte_valid && !link.byte_first) || (link.rd_req && !link.byte_valid)
        |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not advance");
    a_ptr_load: assert property (link.byte_valid && link.byte_first |=> ptr_q == $past(link.byte_data))
        else $error("pointer not loaded");
    a_key_wrong: assert property (link.byte_valid && !link.byte_first && ptr_q == 8'h07
        && link.byte_data != 8'haa |=> !sys_reset_req)
        else $error("reset with wrong key");
    a_reset_pulse: assert property (sys_reset_req |-> $past(link.byte_valid) && key_low_q == 8'h00
        && key_high_q == 8'h00 ##1 !sys_reset_req)
        else $error("reset request malformed");
    a_ro_unchanged: assert property (link.byte_valid && !link.byte_first && ptr_q <= 8'h04
        |=> $stable(op_mode_high_q) && $stable(key_low_q) && $stable(key_high_q))
        else $error("read-only write changed state");

    c_burst_read: cover property (link.rd_req ##[1:300] link.rd_req);
    c_burst_write: cover property (link.byte_valid && link.byte_first ##[1:300] link.byte_valid
        ##[1:300] link.byte_valid);
    c_sys_reset: cover property (sys_reset_req);

endmodule : host_register_map

// ==== verif/i2c_master_model.sv ====
// serial bus master model standing in for the embedded controller
`timescale 1ns/10ps
module i2c_master_model
(
    // clock
    input wire logic mclk,
    // open-drain data line level
    input wire logic sda_line,
    // pull-downs, high = line pulled low
    output logic scl_low,
    output logic sda_low,
    // bytes read from the slave
    output logic got_valid,
    output logic [7:0] got_byte
);
    localparam int half_cycles = 10;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        got_valid = 1'b0;
        got_byte = 8'h00;
    end
    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask : pause
    // start and repeated start alike, clock left low
    task automatic start_bit();
        pause(2);
        sda_low <= 1'b0;
        pause(half_cycles);
        scl_low <= 1'b0;
        pause(half_cycles);
        sda_low <= 1'b1;
        pause(half_cycles);
        scl_low <= 1'b1;
    endtask : start_bit
    task automatic stop_bit();
        pause(2);
        sda_low <= 1'b1;
        pause(half_cycles);
        scl_low <= 1'b0;
        pause(half_cycles);
        sda_low <= 1'b0;
        pause(half_cycles);
    endtask : stop_bit
    // data moves a little after the clock fall, so no false start or stop
    task automatic clock_bit(input logic b, output logic seen);
        pause(2);
        sda_low <= ~b;
        pause(half_cycles - 2);
        scl_low <= 1'b0;
        pause(half_cycles / 2);
        seen = sda_line;
        pause(half_cycles / 2);
        scl_low <= 1'b1;
    endtask : clock_bit
    task automatic put_byte(input logic [7:0] d, output logic acked);
        logic seen;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], seen);
        clock_bit(1'b1, seen);
        acked = ~seen;
    endtask : put_byte
    // every byte acked but the last, which gets a nack
    task automatic get_byte(input logic last);
        logic seen;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, seen);
            v[i] = seen;
        end
        clock_bit(last, seen);
        got_byte <= v;
        got_valid <= 1'b1;
        pause(1);
        got_valid <= 1'b0;
    endtask : get_byte
endmodule : i2c_master_model

// ==== verif/host_register_map_tb_top.sv ====
// self-checking bench for the host register bank over its serial port
`timescale 1ns/10ps
`include "host_register_map_consts.svh"
module host_register_map_tb_top;
    typedef logic [7:0] byte_q_type[$];
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low, got_valid, sys_reset_req, loader_flag;
    logic [7:0] got_byte, op_mode_high, mode_e, klo_e, khi_e;
    logic [7:0] vers [0:3];
    logic [7:0] stat [0:4];
    logic [31:0] lfsr = 32'h0fc1;
    logic [7:0] exp_q [$];
    // sticky record of the pins the slave must never drive
    logic [2:0] pins_or = 3'b000;
    int mismatches = 0, tests_run = 0, pulses_seen = 0, pulses_e = 0, cycles = 0;
    // pull-ups on both lines
    wire logic scl_line = ~((scl_oe & ~scl_out) | scl_low);
    wire logic sda_line = ~((sda_oe & ~sda_out) | sda_low);
    always #5 mclk = ~mclk;
    host_register_map dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .boot_version_minor(vers[0]),
        .boot_version_major(vers[1]), .app_version_minor(vers[2]), .app_version_major(vers[3]),
        .loader_active_flag(loader_flag), .main_event_summary(stat[0]), .event_group_zero(stat[1]),
        .event_group_one(stat[2]), .event_group_two(stat[3]), .event_group_three(stat[4]),
        .op_mode_high(op_mode_high), .sys_reset_req(sys_reset_req));
    i2c_master_model master (.mclk(mclk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low),
        .got_valid(got_valid), .got_byte(got_byte));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        if (a <= `REG_APP_VERSION_MAJOR)
            return vers[a[1:0]];
        if (a == `REG_OP_MODE_LOW)
            return {7'h00, loader_flag};
        if (a == `REG_OP_MODE_HIGH)
            return mode_e;
        if (a == `REG_SYS_RESET_KEY_LOW)
            return klo_e;
        if (a == `REG_SYS_RESET_KEY_HIGH)
            return khi_e;
        if (a < `REG_RESERVED_FIRST)
            return stat[a - `REG_MAIN_EVENT_SUMMARY];
        return `RESERVED_READ_VALUE;
    endfunction : exp_reg
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic mirror_write(input logic [7:0] a, input logic [7:0] d);
        if (a == `REG_OP_MODE_HIGH)
            mode_e = d;
        if (a == `REG_SYS_RESET_KEY_LOW)
            klo_e = d;
        if (a == `REG_SYS_RESET_KEY_HIGH)
            khi_e = d;
        if (klo_e == `SYS_RESET_KEY_LOW_VALUE && khi_e == `SYS_RESET_KEY_HIGH_VALUE)
        begin
            pulses_e++;
            klo_e = `SYS_RESET_KEY_RESET;
            khi_e = `SYS_RESET_KEY_RESET;
        end
    endtask : mirror_write
    task automatic wr(input byte_q_type b);
        logic acked;
        master.start_bit();
        master.put_byte({`I2C_DEV_ADDR, 1'b0}, acked);
        check("write address ack", {7'h00, acked}, 8'h01);
        foreach (b[i])
        begin
            master.put_byte(b[i], acked);
            check("write byte ack", {7'h00, acked}, 8'h01);
            if (i > 0)
                mirror_write(b[0] + 8'(i - 1), b[i]);
        end
        master.stop_bit();
    endtask : wr
    task automatic rd(input logic [7:0] a, input int n);
        logic acked;
        master.start_bit();
        master.put_byte({`I2C_DEV_ADDR, 1'b0}, acked);
        master.put_byte(a, acked);
        master.start_bit();
        master.put_byte({`I2C_DEV_ADDR, 1'b1}, acked);
        check("read address ack", {7'h00, acked}, 8'h01);
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(exp_reg(a + 8'(i)));
            master.get_byte(i == n - 1);
        end
        master.stop_bit();
        check("bytes left unread", 8'(exp_q.size()), 8'h00);
    endtask : rd
    // fresh live values from the lfsr, loader mode as asked
    task automatic scramble(input logic flag);
        @(posedge mclk);
        for (int i = 0; i < 9; i++)
        begin
            lfsr = lfsr_next(lfsr);
            if (i < 4)
                vers[i] <= lfsr[7:0];
            else
                stat[i - 4] <= lfsr[7:0];
        end
        loader_flag <= flag;
        @(posedge mclk);
    endtask : scramble
    task automatic test_done(input string name);
        $display("test %s finished", name);
    endtask : test_done
    // result watcher and hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (rst_n === 1'b1)
            pins_or <= pins_or | {scl_oe, scl_out, sda_out};
        if (cycles == 40000)
        begin
            mismatches++;
            close_out();
        end
        if (sys_reset_req === 1'b1)
            pulses_seen++;
        if (got_valid === 1'b1)
            check("read byte", got_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    initial
    begin
        logic acked;
        foreach (vers[i])
            vers[i] = 8'h00;
        foreach (stat[i])
            stat[i] = 8'h00;
        loader_flag = 1'b0;
        mode_e = `OP_MODE_HIGH_RESET;
        klo_e = `SYS_RESET_KEY_RESET;
        khi_e = `SYS_RESET_KEY_RESET;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("op_mode_high at reset", op_mode_high, `OP_MODE_HIGH_RESET);
        check("reset request at reset", {7'h00, sys_reset_req}, 8'h00);
        test_done("reset");
        for (int f = 0; f < 2; f++)
        begin
            scramble(f[0]);
            rd(`REG_BOOT_VERSION_MINOR, 13);
        end
        test_done("readout");
        rd(8'h7f, 3);
        rd(8'hff, 2);
        test_done("reserved");
        master.start_bit();
        master.put_byte({7'h4a, 1'b0}, acked);
        check("foreign address ack", {7'h00, acked}, 8'h00);
        master.stop_bit();
        rd(`REG_OP_MODE_LOW, 1);
        test_done("address");
        wr('{`REG_SYS_RESET_KEY_LOW, `SYS_RESET_KEY_LOW_VALUE, 8'hab});
        rd(`REG_SYS_RESET_KEY_LOW, 2);
        check("reset pulses", 8'(pulses_seen), 8'(pulses_e));
        lfsr = lfsr_next(lfsr);
        wr('{`REG_APP_VERSION_MAJOR, 8'h5a, 8'ha5, lfsr[7:0], `SYS_RESET_KEY_LOW_VALUE, `SYS_RESET_KEY_HIGH_VALUE});
        check("op_mode_high", op_mode_high, mode_e);
        check("reset pulses", 8'(pulses_seen), 8'(pulses_e));
        rd(`REG_APP_VERSION_MAJOR, 5);
        check("fixed pin drive", {5'h00, pins_or}, 8'h00);
        test_done("keys");
        close_out();
    end
endmodule : host_register_map_tb_top
